// ### verilog/ifr_pkg.sv
package ifr_pkg;

  // Bus and register widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register word offsets on the plain register port
  localparam logic [3:0] OFS_FLAGS_2   = 4'h0;
  localparam logic [3:0] OFS_FLAGS_3   = 4'h1;
  localparam logic [3:0] OFS_FLAGS_4   = 4'h2;
  localparam logic [3:0] OFS_ENABLES_0 = 4'h3;
  localparam logic [3:0] OFS_ENABLES_1 = 4'h4;
  localparam logic [3:0] OFS_STATUS    = 4'h5;
  localparam logic [3:0] OFS_MASK      = 4'h6;

  // Value of every register after reset
  localparam logic [15:0] RST_VAL = 16'h0000;

  // Flag register 2, low bits
  localparam int P_CAN_A_RX_READY    = 2;
  localparam int P_SERIAL_B_EVENT    = 1;
  localparam int P_SERIAL_B_ERROR    = 0;

  // Flag register 3
  localparam int P_DMA_CH5_DONE      = 13;
  localparam int P_CODEC_EVENT       = 12;
  localparam int P_CODEC_ERROR       = 11;
  localparam int P_CAN_B_EVENT       = 8;
  localparam int P_CAN_B_RX_READY    = 7;
  localparam int P_EXT_INPUT4        = 6;
  localparam int P_EXT_INPUT3        = 5;
  localparam int P_TIMER9            = 4;
  localparam int P_TIMER8            = 3;
  localparam int P_TWOWIRE_B_MASTER  = 2;
  localparam int P_TWOWIRE_B_SLAVE   = 1;
  localparam int P_TIMER7            = 0;

  // Flag register 4
  localparam int P_CAN_B_TX_REQUEST  = 7;
  localparam int P_CAN_A_TX_REQUEST  = 6;
  localparam int P_DMA_CH7_DONE      = 5;
  localparam int P_DMA_CH6_DONE      = 4;
  localparam int P_UART_B_ERROR      = 2;
  localparam int P_UART_A_ERROR      = 1;

  // Enable register 0: bits 14 down to 0 exist, bit 15 does not
  localparam int P_EN0_TOP           = 14;
  // Enable register 1: every bit exists except this one
  localparam int P_EN1_HOLE          = 2;

  // Status bits of the block's own interrupt
  localparam int P_ST_NEW_2          = 0;
  localparam int P_ST_NEW_3          = 1;
  localparam int P_ST_NEW_4          = 2;
  localparam int P_ST_BAD_ADDR       = 3;
  localparam int ST_BITS             = 4;

  // Register selected by an address
  typedef enum {
    IFR_SEL_F2,
    IFR_SEL_F3,
    IFR_SEL_F4,
    IFR_SEL_E0,
    IFR_SEL_E1,
    IFR_SEL_ST,
    IFR_SEL_MK,
    IFR_SEL_NONE
  } ifr_sel_t;

  // One access on the register port
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ifr_bus_t;

  // Gated requests toward arbitration, one vector per flag register
  typedef struct packed {
    logic [DATA_W-1:0] r0;
    logic [DATA_W-1:0] r1;
    logic [DATA_W-1:0] r2;
    logic [DATA_W-1:0] r3;
    logic [DATA_W-1:0] r4;
  } ifr_req_t;

endpackage

// ### verilog/ifr_regs.sv
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
// Behaviour
// - A flag bit reads 1 once its source has raised a request.
// - A flag bit reads 0 while its source has no pending request.
// - An enable bit at 1 lets the matching request through to arbitration.
// - An enable bit at 0 blocks the matching request whatever its flag.
// - Unimplemented bit positions ignore writes and always read zero.
// - Software can read, set and clear every implemented flag and enable bit.
// - Every implemented flag and enable bit is 0 after reset.
// - Flags 2 hold CAN A receive at 2, serial B event 1, error 0.
// - Flags 3 upper: DMA5 13, codec 12/11, CAN B 8, 7; 15-14, 10-9 absent.
// - Flags 3 low: ext 4/3, timers 9/8, two-wire B master/slave, timer 7.
// - Flags 4: CAN B/A transmit at 7/6, DMA 7/6 at 5/4; 15-8 absent.
// - Flags 4: UART B/A error at 2/1; bits 3 and 0 absent.
// - Enables 0 upper byte: bits 14 to 8 exist, bit 15 absent.
// - Enables 0 lower byte: timer2 down to ext input 0, all eight bits.
// - Enables 1 upper byte: UART B tx down to DMA2, all eight bits.
// - Enables 1 lower byte: capture 8 down to two-wire A slave, bit 2 absent.
module ifr_regs (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire ifr_pkg::ifr_bus_t bus,
  input  wire logic [15:0]      evt_2,
  input  wire logic [15:0]      evt_3,
  input  wire logic [15:0]      evt_4,
  input  wire logic [15:0]      ext_flags_0,
  input  wire logic [15:0]      ext_flags_1,
  input  wire logic [15:0]      ext_en_2,
  input  wire logic [15:0]      ext_en_3,
  input  wire logic [15:0]      ext_en_4,
  output logic [15:0]           rd_data,
  output logic [15:0]           flags_2,
  output logic [15:0]           flags_3,
  output logic [15:0]           flags_4,
  output logic [15:0]           en_0,
  output logic [15:0]           en_1,
  output ifr_pkg::ifr_req_t     req,
  output logic                  irq
);

  // One-hot bit at a position
  function automatic logic [15:0] bit_at(input int pos);
    bit_at = 16'h0001 << pos;
  endfunction

  // Register selected by an address
  function automatic ifr_pkg::ifr_sel_t sel_of(input logic [3:0] addr);
    case (addr)
      ifr_pkg::OFS_FLAGS_2:   sel_of = ifr_pkg::IFR_SEL_F2;
      ifr_pkg::OFS_FLAGS_3:   sel_of = ifr_pkg::IFR_SEL_F3;
      ifr_pkg::OFS_FLAGS_4:   sel_of = ifr_pkg::IFR_SEL_F4;
      ifr_pkg::OFS_ENABLES_0: sel_of = ifr_pkg::IFR_SEL_E0;
      ifr_pkg::OFS_ENABLES_1: sel_of = ifr_pkg::IFR_SEL_E1;
      ifr_pkg::OFS_STATUS:    sel_of = ifr_pkg::IFR_SEL_ST;
      ifr_pkg::OFS_MASK:      sel_of = ifr_pkg::IFR_SEL_MK;
      default:                sel_of = ifr_pkg::IFR_SEL_NONE;
    endcase
  endfunction

  // Software write merged with hardware set; the set wins, absent bits drop
  function automatic logic [15:0] merge(input logic [15:0] cur,
                                        input logic        wr,
                                        input logic [15:0] wdata,
                                        input logic [15:0] set,
                                        input logic [15:0] impl);
    merge = ((wr ? wdata : cur) | set) & impl;
  endfunction

  logic [15:0]       impl_2;
  logic [15:0]       impl_3;
  logic [15:0]       impl_4;
  logic [15:0]       impl_e0;
  logic [15:0]       impl_e1;
  logic [15:0]       impl_st;
  ifr_pkg::ifr_sel_t sel;
  logic              wr_f2;
  logic              wr_f3;
  logic              wr_f4;
  logic              wr_e0;
  logic              wr_e1;
  logic              wr_st;
  logic              wr_mk;
  logic              bad_access;
  logic [15:0]       status;
  logic [15:0]       mask;
  logic [15:0]       st_set;
  logic [15:0]       st_clr;
  logic [15:0]       rd_mux;
  logic [15:0]       next_flags_2;
  logic [15:0]       next_flags_3;
  logic [15:0]       next_flags_4;
  logic [15:0]       next_en_0;
  logic [15:0]       next_en_1;
  logic [15:0]       next_status;
  logic [15:0]       next_mask;
  ifr_pkg::ifr_req_t next_req;
  logic              next_irq;

  // Implemented bits of flag register 2 (only its low bits live here)
  assign impl_2 = bit_at(ifr_pkg::P_CAN_A_RX_READY)
                | bit_at(ifr_pkg::P_SERIAL_B_EVENT)
                | bit_at(ifr_pkg::P_SERIAL_B_ERROR);

  // Implemented bits of flag register 3
  assign impl_3 = bit_at(ifr_pkg::P_DMA_CH5_DONE)
                | bit_at(ifr_pkg::P_CODEC_EVENT)
                | bit_at(ifr_pkg::P_CODEC_ERROR)
                | bit_at(ifr_pkg::P_CAN_B_EVENT)
                | bit_at(ifr_pkg::P_CAN_B_RX_READY)
                | bit_at(ifr_pkg::P_EXT_INPUT4)
                | bit_at(ifr_pkg::P_EXT_INPUT3)
                | bit_at(ifr_pkg::P_TIMER9)
                | bit_at(ifr_pkg::P_TIMER8)
                | bit_at(ifr_pkg::P_TWOWIRE_B_MASTER)
                | bit_at(ifr_pkg::P_TWOWIRE_B_SLAVE)
                | bit_at(ifr_pkg::P_TIMER7);

  // Implemented bits of flag register 4
  assign impl_4 = bit_at(ifr_pkg::P_CAN_B_TX_REQUEST)
                | bit_at(ifr_pkg::P_CAN_A_TX_REQUEST)
                | bit_at(ifr_pkg::P_DMA_CH7_DONE)
                | bit_at(ifr_pkg::P_DMA_CH6_DONE)
                | bit_at(ifr_pkg::P_UART_B_ERROR)
                | bit_at(ifr_pkg::P_UART_A_ERROR);

  // Implemented bits of the enable registers and the block's own status
  assign impl_e0 = (bit_at(ifr_pkg::P_EN0_TOP) << 1) - 16'h0001;
  assign impl_e1 = ~bit_at(ifr_pkg::P_EN1_HOLE);
  assign impl_st = bit_at(ifr_pkg::ST_BITS) - 16'h0001;

  // Address decode and write strobes
  assign sel        = sel_of(bus.addr);
  assign wr_f2      = bus.wr && (sel == ifr_pkg::IFR_SEL_F2);
  assign wr_f3      = bus.wr && (sel == ifr_pkg::IFR_SEL_F3);
  assign wr_f4      = bus.wr && (sel == ifr_pkg::IFR_SEL_F4);
  assign wr_e0      = bus.wr && (sel == ifr_pkg::IFR_SEL_E0);
  assign wr_e1      = bus.wr && (sel == ifr_pkg::IFR_SEL_E1);
  assign wr_st      = bus.wr && (sel == ifr_pkg::IFR_SEL_ST);
  assign wr_mk      = bus.wr && (sel == ifr_pkg::IFR_SEL_MK);
  assign bad_access = (bus.wr || bus.rd) && (sel == ifr_pkg::IFR_SEL_NONE);

  // Flags: source events set, software writes either way, set beats clear
  assign next_flags_2 = merge(flags_2, wr_f2, bus.wdata, evt_2, impl_2);
  assign next_flags_3 = merge(flags_3, wr_f3, bus.wdata, evt_3, impl_3);
  assign next_flags_4 = merge(flags_4, wr_f4, bus.wdata, evt_4, impl_4);

  // Enables: software only
  assign next_en_0 = merge(en_0, wr_e0, bus.wdata, ifr_pkg::RST_VAL, impl_e0);
  assign next_en_1 = merge(en_1, wr_e1, bus.wdata, ifr_pkg::RST_VAL, impl_e1);

  // Requests to arbitration need both flag and enable
  assign next_req.r0 = ext_flags_0 & next_en_0;
  assign next_req.r1 = ext_flags_1 & next_en_1;
  assign next_req.r2 = next_flags_2 & ext_en_2;
  assign next_req.r3 = next_flags_3 & ext_en_3;
  assign next_req.r4 = next_flags_4 & ext_en_4;

  // Own status: a newly raised flag per register, or an unmapped access
  assign st_set = ({15'h0000, |(evt_2 & impl_2 & ~flags_2)} << ifr_pkg::P_ST_NEW_2)
                | ({15'h0000, |(evt_3 & impl_3 & ~flags_3)} << ifr_pkg::P_ST_NEW_3)
                | ({15'h0000, |(evt_4 & impl_4 & ~flags_4)} << ifr_pkg::P_ST_NEW_4)
                | ({15'h0000, bad_access} << ifr_pkg::P_ST_BAD_ADDR);
  assign st_clr      = wr_st ? bus.wdata : ifr_pkg::RST_VAL;
  assign next_status = ((status & ~st_clr) | st_set) & impl_st;
  assign next_mask   = merge(mask, wr_mk, bus.wdata, ifr_pkg::RST_VAL, impl_st);
  assign next_irq    = |(next_status & next_mask);

  // Read selection; absent bits are already zero in storage
  assign rd_mux = (sel == ifr_pkg::IFR_SEL_F2) ? flags_2 :
                  (sel == ifr_pkg::IFR_SEL_F3) ? flags_3 :
                  (sel == ifr_pkg::IFR_SEL_F4) ? flags_4 :
                  (sel == ifr_pkg::IFR_SEL_E0) ? en_0    :
                  (sel == ifr_pkg::IFR_SEL_E1) ? en_1    :
                  (sel == ifr_pkg::IFR_SEL_ST) ? status  :
                  (sel == ifr_pkg::IFR_SEL_MK) ? mask    :
                  ifr_pkg::RST_VAL;

  // Register storage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_2 <= ifr_pkg::RST_VAL;
      flags_3 <= ifr_pkg::RST_VAL;
      flags_4 <= ifr_pkg::RST_VAL;
      en_0    <= ifr_pkg::RST_VAL;
      en_1    <= ifr_pkg::RST_VAL;
      status  <= ifr_pkg::RST_VAL;
      mask    <= ifr_pkg::RST_VAL;
    end else begin
      flags_2 <= next_flags_2;
      flags_3 <= next_flags_3;
      flags_4 <= next_flags_4;
      en_0    <= next_en_0;
      en_1    <= next_en_1;
      status  <= next_status;
      mask    <= next_mask;
    end
  end

  // Registered outputs: requests, interrupt and read data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req     <= '0;
      irq     <= 1'b0;
      rd_data <= ifr_pkg::RST_VAL;
    end else begin
      req     <= next_req;
      irq     <= next_irq;
      rd_data <= bus.rd ? rd_mux : ifr_pkg::RST_VAL;
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Event and software clear in the same cycle
  sequence s_evt_with_clear3;
    wr_f3 && ((evt_3 & impl_3 & ~bus.wdata) != 16'h0000);
  endsequence

  // A quiet cycle on flag register 3
  sequence s_quiet3;
    !wr_f3 && ((evt_3 & impl_3) == 16'h0000);
  endsequence

  // A read of enable register 1
  sequence s_read_en1;
    bus.rd && (bus.addr == ifr_pkg::OFS_ENABLES_1);
  endsequence

  // A read of flag register 3
  sequence s_read_f3;
    bus.rd && (bus.addr == ifr_pkg::OFS_FLAGS_3);
  endsequence

  // Events on flag register 3 with no software write
  sequence s_evt3_only;
    !wr_f3 && ((evt_3 & impl_3) != 16'h0000);
  endsequence

  a_event_sets_flag: assert property (
    ((evt_2 & impl_2) != 16'h0000) |=> ((flags_2 & $past(evt_2 & impl_2)) == $past(evt_2 & impl_2))
  ) else $error("flag 2 did not latch its event");

  a_flag_holds_idle: assert property (
    s_quiet3 |=> (flags_3 == $past(flags_3))
  ) else $error("flag 3 changed without event or write");

  a_set_beats_clear: assert property (
    s_evt_with_clear3 |=> ((flags_3 & $past(evt_3 & impl_3)) != 16'h0000)
  ) else $error("event lost against software clear");

  a_flag_stays_set: assert property (
    (flags_4 != 16'h0000) && !wr_f4 |=> ((flags_4 & $past(flags_4)) == $past(flags_4))
  ) else $error("flag 4 bit dropped without a write");

  a_enable_passes: assert property (
    1'b1 |=> (req.r0 == ($past(ext_flags_0) & en_0))
  ) else $error("request 0 not flag and enable");

  a_enable_blocks: assert property (
    (next_en_1 == 16'h0000) |=> (req.r1 == 16'h0000)
  ) else $error("disabled source reached arbitration");

  a_req_needs_both: assert property (
    1'b1 |=> (req.r3 == (flags_3 & $past(ext_en_3)))
  ) else $error("request 3 not flag and enable");

  a_unimpl_zero: assert property (
    ((flags_2 & ~impl_2) == 16'h0000) && ((flags_3 & ~impl_3) == 16'h0000)
    && ((flags_4 & ~impl_4) == 16'h0000) && ((en_0 & ~impl_e0) == 16'h0000)
    && ((en_1 & ~impl_e1) == 16'h0000)
  ) else $error("unimplemented bit holds a one");

  a_sw_write_flag: assert property (
    wr_f4 && ((evt_4 & impl_4) == 16'h0000) |=> (flags_4 == ($past(bus.wdata) & impl_4))
  ) else $error("flag 4 write not stored");

  a_sw_write_en: assert property (
    wr_e0 |=> (en_0 == ($past(bus.wdata) & impl_e0))
  ) else $error("enable 0 write not stored");

  a_read_returns: assert property (
    s_read_en1 |=> (rd_data == $past(en_1))
  ) else $error("read of enable 1 wrong");

  a_read_idle_zero: assert property (
    !bus.rd |=> (rd_data == 16'h0000)
  ) else $error("read data not zero without read");

  a_reset_clears: assert property (
    @(posedge clk) disable iff (1'b0)
    sys_rst |=> (flags_2 == 16'h0000) && (flags_3 == 16'h0000) && (flags_4 == 16'h0000)
               && (en_0 == 16'h0000) && (en_1 == 16'h0000) && !irq
  ) else $error("registers not cleared by reset");

  a_layout_flags3: assert property (
    wr_f3 && ((evt_3 & impl_3) == 16'h0000) |=> (flags_3 == ($past(bus.wdata) & 16'h39ff))
  ) else $error("flag 3 layout wrong");

  a_layout_flags4: assert property (
    wr_f4 && ((evt_4 & impl_4) == 16'h0000) |=> ((flags_4 & 16'hff09) == 16'h0000)
  ) else $error("flag 4 layout wrong");

  a_layout_en1: assert property (
    wr_e1 |=> (en_1 == ($past(bus.wdata) & 16'hfffb))
  ) else $error("enable 1 layout wrong");

  a_event_sets_f3: assert property (
    ((evt_3 & impl_3) != 16'h0000) |=> ((flags_3 & $past(evt_3 & impl_3)) == $past(evt_3 & impl_3))
  ) else $error("flag 3 did not latch its event");

  a_event_sets_f4: assert property (
    ((evt_4 & impl_4) != 16'h0000) |=> ((flags_4 & $past(evt_4 & impl_4)) == $past(evt_4 & impl_4))
  ) else $error("flag 4 did not latch its event");

  a_flag2_holds_idle: assert property (
    !wr_f2 && ((evt_2 & impl_2) == 16'h0000) |=> (flags_2 == $past(flags_2))
  ) else $error("flag 2 changed without event or write");

  a_flag4_holds_idle: assert property (
    !wr_f4 && ((evt_4 & impl_4) == 16'h0000) |=> (flags_4 == $past(flags_4))
  ) else $error("flag 4 changed without event or write");

  a_req2_needs_both: assert property (
    1'b1 |=> (req.r2 == (flags_2 & $past(ext_en_2)))
  ) else $error("request 2 not flag and enable");

  a_req4_needs_both: assert property (
    1'b1 |=> (req.r4 == (flags_4 & $past(ext_en_4)))
  ) else $error("request 4 not flag and enable");

  a_enable1_passes: assert property (
    1'b1 |=> (req.r1 == ($past(ext_flags_1) & en_1))
  ) else $error("request 1 not flag and enable");

  a_en0_blocks: assert property (
    (next_en_0 == 16'h0000) |=> (req.r0 == 16'h0000)
  ) else $error("disabled source 0 reached arbitration");

  a_req3_blocked: assert property (
    (ext_en_3 == 16'h0000) |=> (req.r3 == 16'h0000)
  ) else $error("disabled source 3 reached arbitration");

  a_layout_flags2: assert property (
    wr_f2 && ((evt_2 & impl_2) == 16'h0000) |=> (flags_2 == ($past(bus.wdata) & 16'h0007))
  ) else $error("flag 2 layout wrong");

  a_layout_flags4w: assert property (
    wr_f4 && ((evt_4 & impl_4) == 16'h0000) |=> (flags_4 == ($past(bus.wdata) & 16'h00f6))
  ) else $error("flag 4 write layout wrong");

  a_layout_en0: assert property (
    wr_e0 |=> (en_0 == ($past(bus.wdata) & 16'h7fff))
  ) else $error("enable 0 layout wrong");

  a_unmapped_reads: assert property (
    bus.rd && (sel == ifr_pkg::IFR_SEL_NONE) |=> (rd_data == 16'h0000)
  ) else $error("unmapped read not zero");

  a_read_flags3: assert property (
    s_read_f3 |=> (rd_data == $past(flags_3))
  ) else $error("read of flag 3 wrong");

  a_read_en0: assert property (
    bus.rd && (bus.addr == ifr_pkg::OFS_ENABLES_0) |=> (rd_data == $past(en_0))
  ) else $error("read of enable 0 wrong");

  a_flag_persists: assert property (
    s_evt3_only ##1 s_quiet3 |=> ((flags_3 & $past(evt_3 & impl_3, 2)) == $past(evt_3 & impl_3, 2))
  ) else $error("flag 3 lost after its event ended");

  a_flag3_stays_set: assert property (
    !wr_f3 |=> ((flags_3 & $past(flags_3)) == $past(flags_3))
  ) else $error("flag 3 bit dropped without a write");

  a_irq_level: assert property (
    irq == ((status & mask) != 16'h0000)
  ) else $error("interrupt not tied to masked status");

endmodule

// ### verification/ifr_periph_model.sv
`timescale 1ns/1ns
// Peripheral side: each source raises a one-cycle event burst on request
module ifr_periph_model (
  input  wire logic        clk,
  output logic [15:0]      evt_2,
  output logic [15:0]      evt_3,
  output logic [15:0]      evt_4
);
  // Idle sources keep every event low
  initial begin
    evt_2 = 16'h0000;
    evt_3 = 16'h0000;
    evt_4 = 16'h0000;
  end

  // Pulse the chosen sources for exactly one clock
  task automatic raise(input int sel, input logic [15:0] bits);
    @(posedge clk);
    case (sel)
      2: evt_2 <= bits;
      3: evt_3 <= bits;
      default: evt_4 <= bits;
    endcase
    @(posedge clk);
    evt_2 <= 16'h0000;
    evt_3 <= 16'h0000;
    evt_4 <= 16'h0000;
  endtask
endmodule

// ### verification/interrupt_flag_enable_regs_tb.sv
`timescale 1ns/1ns
module interrupt_flag_enable_regs_tb;
  logic              clk;
  logic              sys_rst;
  ifr_pkg::ifr_bus_t bus;
  logic [15:0]       evt_2, evt_3, evt_4;
  logic [15:0]       ext_flags_0, ext_flags_1, ext_en_2, ext_en_3, ext_en_4;
  logic [15:0]       rd_data, flags_2, flags_3, flags_4, en_0, en_1;
  ifr_pkg::ifr_req_t req;
  logic              irq;
  int                fail_count, total_checks, cycles;
  logic [3:0]        addr_tab [5];
  logic [15:0]       impl_tab [5];

  ifr_regs ifr_regs_inst (.clk(clk), .sys_rst(sys_rst), .bus(bus), .evt_2(evt_2), .evt_3(evt_3),
    .evt_4(evt_4), .ext_flags_0(ext_flags_0), .ext_flags_1(ext_flags_1), .ext_en_2(ext_en_2),
    .ext_en_3(ext_en_3), .ext_en_4(ext_en_4), .rd_data(rd_data), .flags_2(flags_2), .flags_3(flags_3),
    .flags_4(flags_4), .en_0(en_0), .en_1(en_1), .req(req), .irq(irq));
  ifr_periph_model ifr_periph_model_inst (.clk(clk), .evt_2(evt_2), .evt_3(evt_3), .evt_4(evt_4));

  // 25 MHz clock
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Counts: %0d mismatches in %0d checks", fail_count, total_checks);
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // One-cycle write strobe, then idle
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
  endtask

  // One-cycle read strobe; data taken in the following cycle
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b0};
    #1 chk_word(rd_data, exp, what);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  initial begin
    bus = '0;
    sys_rst = 1'b1;
    {ext_flags_0, ext_flags_1, ext_en_2, ext_en_3, ext_en_4} = '0;
    {fail_count, total_checks, cycles} = '0;
    addr_tab = '{ifr_pkg::OFS_FLAGS_2, ifr_pkg::OFS_FLAGS_3, ifr_pkg::OFS_FLAGS_4,
                 ifr_pkg::OFS_ENABLES_0, ifr_pkg::OFS_ENABLES_1};
    // Implemented bits of each register
    impl_tab = '{16'h0007, 16'h39ff, 16'h00f6, 16'h7fff, 16'hfffb};
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values
    for (int i = 0; i < 5; i++) rd_chk(addr_tab[i], 16'h0000, "reset value");
    rd_chk(ifr_pkg::OFS_STATUS, 16'h0000, "status reset");
    chk_bit(irq, 1'b0, "irq after reset");
    // Software sets and clears every bit; absent bits stay zero
    for (int i = 0; i < 5; i++) begin
      wr_reg(addr_tab[i], 16'hffff);
      rd_chk(addr_tab[i], impl_tab[i], "write ones");
      wr_reg(addr_tab[i], 16'h0000);
      rd_chk(addr_tab[i], 16'h0000, "write zeros");
    end
    wr_reg(ifr_pkg::OFS_STATUS, 16'h000f);
    // Source events set exactly the implemented flags
    for (int i = 0; i < 3; i++) begin
      ifr_periph_model_inst.raise(i + 2, 16'hffff);
      idle(1);
      rd_chk(addr_tab[i], impl_tab[i], "event flags");
    end
    rd_chk(ifr_pkg::OFS_STATUS, 16'h0007, "new flag status");
    // Flags hold after the events end
    idle(3);
    chk_word(flags_2, 16'h0007, "flag 2 held");
    chk_word(flags_3, 16'h39ff, "flag held");
    chk_word(flags_4, 16'h00f6, "flag 4 held");
    // Enables gate the requests
    @(posedge clk);
    ext_en_2 <= 16'hffff;
    ext_en_3 <= 16'h00ff;
    ext_en_4 <= 16'h0042;
    idle(2);
    chk_word(req.r2, 16'h0007, "req r2 enabled");
    chk_word(req.r3, 16'h00ff, "req r3 enabled");
    chk_word(req.r4, 16'h0042, "req r4 partial");
    @(posedge clk);
    ext_en_2 <= 16'h0000;
    ext_en_3 <= 16'h0000;
    ext_en_4 <= 16'h0000;
    idle(2);
    chk_word(req.r2, 16'h0000, "req r2 blocked");
    chk_word(req.r3, 16'h0000, "req r3 blocked");
    chk_word(req.r4, 16'h0000, "req r4 blocked");
    @(posedge clk);
    ext_flags_0 <= 16'hffff;
    ext_flags_1 <= 16'hffff;
    wr_reg(ifr_pkg::OFS_ENABLES_0, 16'hffff);
    wr_reg(ifr_pkg::OFS_ENABLES_1, 16'h00f0);
    idle(2);
    chk_word(req.r0, 16'h7fff, "req r0 enabled");
    chk_word(req.r1, 16'h00f0, "req r1 partial");
    chk_word(en_0, 16'h7fff, "enable 0 port");
    chk_word(en_1, 16'h00f0, "enable 1 port");
    wr_reg(ifr_pkg::OFS_ENABLES_0, 16'h0000);
    idle(2);
    chk_word(req.r0, 16'h0000, "req r0 blocked");
    // Block interrupt: masked, unmasked, cleared
    chk_bit(irq, 1'b0, "irq masked");
    wr_reg(ifr_pkg::OFS_MASK, 16'h0002);
    idle(2);
    chk_bit(irq, 1'b1, "irq unmasked");
    // Handler clears its flag, then the status bit
    wr_reg(ifr_pkg::OFS_FLAGS_3, 16'h0000);
    rd_chk(ifr_pkg::OFS_FLAGS_3, 16'h0000, "flag cleared");
    // Event and software clear in the same cycle: the event wins, bit 9 is absent
    fork
      ifr_periph_model_inst.raise(3, 16'h0201);
      wr_reg(ifr_pkg::OFS_FLAGS_3, 16'h0000);
    join
    #1 chk_word(flags_3, 16'h0001, "set beats clear");
    wr_reg(ifr_pkg::OFS_STATUS, 16'h0002);
    idle(2);
    chk_bit(irq, 1'b0, "irq cleared");
    rd_chk(ifr_pkg::OFS_STATUS, 16'h0005, "status after clear");
    // Unmapped address
    wr_reg(4'hf, 16'hffff);
    rd_chk(4'hf, 16'h0000, "unmapped read");
    rd_chk(ifr_pkg::OFS_STATUS, 16'h000d, "unmapped status");
    wr_reg(ifr_pkg::OFS_MASK, 16'hffff);
    rd_chk(ifr_pkg::OFS_MASK, 16'h000f, "mask width");
    idle(2);
    chk_bit(irq, 1'b1, "irq all unmasked");
    // Back-to-back reads; data stand one cycle only
    @(posedge clk);
    bus <= '{addr: ifr_pkg::OFS_FLAGS_4, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '{addr: ifr_pkg::OFS_ENABLES_1, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    #1 chk_word(rd_data, 16'h00f6, "first of pair");
    @(posedge clk);
    bus <= '0;
    #1 chk_word(rd_data, 16'h00f0, "second of pair");
    idle(1);
    chk_word(rd_data, 16'h0000, "read data released");
    // Second reset in mid-run
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(ifr_pkg::OFS_FLAGS_4, 16'h0000, "flags after reset");
    rd_chk(ifr_pkg::OFS_ENABLES_1, 16'h0000, "enables after reset");
    chk_bit(irq, 1'b0, "irq after second reset");
    print_verdict();
  end
endmodule
